// [free_running_timer_capture.sv]
// Free-running 16-bit timer with interval, tick, wrap and two capture channels
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none

module free_running_timer_capture (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        capture_input_a,
   input  wire logic        capture_input_b,
   output var  logic        irq
);

   localparam int US_W = $clog2(timer_pkg::CYCLES_PER_US + 1);
   localparam logic [US_W-1:0] US_LAST = US_W'(timer_pkg::CYCLES_PER_US - 1);
   localparam logic [9:0] TICK_LAST = 10'(timer_pkg::TICK_1MS_COUNT - 1);

   initial begin
      if (timer_pkg::CYCLES_PER_US < 1) begin
         $error("Clock too slow for a one microsecond tick");
      end
   end

   logic [US_W-1:0]                   us_div;
   logic                              us_tick;
   logic [15:0]                       count;
   logic [15:0]                       interval;
   logic [15:0]                       interval_cnt;
   logic [9:0]                        tick_cnt;
   logic [timer_pkg::CTL_WIDTH-1:0]   control;
   logic [timer_pkg::ST_WIDTH-1:0]    status;
   logic [timer_pkg::ST_WIDTH-1:0]    mask;
   logic [timer_pkg::ST_WIDTH-1:0]    events;
   logic [7:0]                        slice;
   logic [2:0]                        shift;
   logic                              gang;
   logic                              rise_a;
   logic                              fall_a;
   logic                              rise_b;
   logic                              fall_b;
   logic                              ev_a;
   logic                              ev_b;
   timer_pkg::capture_pair_type       held_a;
   timer_pkg::capture_pair_type       held_b;
   logic [15:0]                       gang_rise;
   logic [15:0]                       gang_fall;

   // ****************************************************************
   // Microsecond prescaler and free-running counter
   // ****************************************************************
   assign us_tick = (us_div == US_LAST);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         us_div <= '0;
      end else if (us_tick) begin
         us_div <= '0;
      end else begin
         us_div <= us_div + US_W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= 16'h0000;
      end else if (us_tick) begin
         count <= count + 16'h0001;
      end
   end

   // ****************************************************************
   // Interval, tick and wrap events
   // ****************************************************************
   // Interval runs off its own down counter; a rewrite takes effect at the next reload, or at once while disabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interval_cnt <= 16'h0000;
      end else if (!control[timer_pkg::CTL_INTERVAL_EN]) begin
         interval_cnt <= interval;
      end else if (us_tick) begin
         if (interval_cnt == 16'h0000) begin
            interval_cnt <= interval;
         end else begin
            interval_cnt <= interval_cnt - 16'h0001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt <= 10'h000;
      end else if (us_tick) begin
         tick_cnt <= (tick_cnt == TICK_LAST) ? 10'h000 : tick_cnt + 10'h001;
      end
   end

   // In gang mode only channel A sets status; channel B's capture event is dropped
   always_comb begin
      events = '0;
      events[timer_pkg::ST_INTERVAL] = us_tick && control[timer_pkg::CTL_INTERVAL_EN]
                                       && (interval_cnt == 16'h0000);
      events[timer_pkg::ST_TICK]     = us_tick && (tick_cnt == TICK_LAST);
      events[timer_pkg::ST_WRAP]     = us_tick && (count == 16'hFFFF);
      events[timer_pkg::ST_CAP_A]    = ev_a;
      events[timer_pkg::ST_CAP_B]    = ev_b && !gang;
   end

   // ****************************************************************
   // Capture channels
   // ****************************************************************
   assign gang  = control[timer_pkg::CTL_GANG];
   assign shift = control[timer_pkg::CTL_SHIFT_LSB +: 3];
   assign slice = 8'(count >> shift);

   edge_capture cap_a (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .pin         (capture_input_a),
      .rise_en     (control[timer_pkg::CTL_RISE_EN_A]),
      .fall_en     (control[timer_pkg::CTL_FALL_EN_A]),
      .slice       (slice),
      .rise_seen   (rise_a),
      .fall_seen   (fall_a),
      .held        (held_a),
      .event_pulse (ev_a)
   );

   edge_capture cap_b (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .pin         (capture_input_b),
      .rise_en     (control[timer_pkg::CTL_RISE_EN_B]),
      .fall_en     (control[timer_pkg::CTL_FALL_EN_B]),
      .slice       (slice),
      .rise_seen   (rise_b),
      .fall_seen   (fall_b),
      .held        (held_b),
      .event_pulse (ev_b)
   );

   // Ganged: input A's edges latch the whole counter into one 16-bit pair
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gang_rise <= 16'h0000;
         gang_fall <= 16'h0000;
      end else if (gang) begin
         if (rise_a && control[timer_pkg::CTL_RISE_EN_A]) begin
            gang_rise <= count;
         end
         if (fall_a && control[timer_pkg::CTL_FALL_EN_A]) begin
            gang_fall <= count;
         end
      end
   end

   // ****************************************************************
   // Interrupt status and output
   // ****************************************************************
   logic        wr_fire;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= '0;
      end else begin
         // Set wins over a simultaneous write-one clear
         if (wr_fire && wr_addr == timer_pkg::ADDR_STATUS) begin
            status <= (status & ~wr_data[timer_pkg::ST_WIDTH-1:0]) | events;
         end else begin
            status <= status | events;
         end
      end
   end

   assign irq = |(status & mask);

   // ****************************************************************
   // AXI4-Lite slave
   // ****************************************************************
   logic        aw_held;
   logic        w_held;
   logic [3:0]  wr_strb;
   logic        wr_ok;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
         end
      end
   end

   always_comb begin
      case (wr_addr)
         timer_pkg::ADDR_INTERVAL,
         timer_pkg::ADDR_CONTROL,
         timer_pkg::ADDR_STATUS,
         timer_pkg::ADDR_MASK: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // Byte lanes above the low half are ignored; all writable fields sit below bit 16
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interval <= timer_pkg::INTERVAL_RESET;
         control  <= timer_pkg::CTL_RESET;
         mask     <= '0;
      end else if (wr_fire) begin
         if (wr_addr == timer_pkg::ADDR_INTERVAL) begin
            if (wr_strb[0]) interval[7:0]  <= wr_data[7:0];
            if (wr_strb[1]) interval[15:8] <= wr_data[15:8];
         end
         if (wr_addr == timer_pkg::ADDR_CONTROL) begin
            if (wr_strb[0]) control[7:0] <= wr_data[7:0];
            if (wr_strb[1]) control[8]   <= wr_data[8];
         end
         if (wr_addr == timer_pkg::ADDR_MASK && wr_strb[0]) begin
            mask <= wr_data[timer_pkg::ST_WIDTH-1:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= timer_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read path: one register stage, answer the cycle after the address is taken
   logic [31:0] rd_mux;
   logic        rd_ok;

   always_comb begin
      rd_ok  = 1'b1;
      rd_mux = 32'h0000_0000;
      case (s_axi_araddr)
         timer_pkg::ADDR_COUNT:    rd_mux[15:0] = count;
         timer_pkg::ADDR_INTERVAL: rd_mux[15:0] = interval;
         timer_pkg::ADDR_CONTROL:  rd_mux[timer_pkg::CTL_WIDTH-1:0] = control;
         timer_pkg::ADDR_STATUS:   rd_mux[timer_pkg::ST_WIDTH-1:0] = status;
         timer_pkg::ADDR_MASK:     rd_mux[timer_pkg::ST_WIDTH-1:0] = mask;
         timer_pkg::ADDR_A_RISE:   rd_mux[15:0] = gang ? gang_rise : {8'h00, held_a.rise};
         timer_pkg::ADDR_A_FALL:   rd_mux[15:0] = gang ? gang_fall : {8'h00, held_a.fall};
         timer_pkg::ADDR_B_RISE:   rd_mux[7:0]  = held_b.rise;
         timer_pkg::ADDR_B_FALL:   rd_mux[7:0]  = held_b.fall;
         default:                  rd_ok = 1'b0;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= timer_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_ok ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// [timer_pkg.sv]
// Package: register map, field layouts and timing constants of the free-running timer
package timer_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLOCK_HZ       = 100_000_000;
   localparam int TICK_NS        = 1000;
   localparam int CYCLES_PER_US  = (CLOCK_HZ / 1_000_000) * TICK_NS / 1000;
   localparam int TICK_1MS_COUNT = 1024;
   localparam int COUNT_WIDTH    = 16;

   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam logic [7:0] ADDR_COUNT     = 8'h00;
   localparam logic [7:0] ADDR_INTERVAL  = 8'h04;
   localparam logic [7:0] ADDR_CONTROL   = 8'h08;
   localparam logic [7:0] ADDR_STATUS    = 8'h0C;
   localparam logic [7:0] ADDR_MASK      = 8'h10;
   localparam logic [7:0] ADDR_A_RISE    = 8'h14;
   localparam logic [7:0] ADDR_A_FALL    = 8'h18;
   localparam logic [7:0] ADDR_B_RISE    = 8'h1C;
   localparam logic [7:0] ADDR_B_FALL    = 8'h20;

   // ****************************************************************
   // Control fields
   // ****************************************************************
   localparam int CTL_INTERVAL_EN = 0;
   localparam int CTL_RISE_EN_A   = 1;
   localparam int CTL_FALL_EN_A   = 2;
   localparam int CTL_RISE_EN_B   = 3;
   localparam int CTL_FALL_EN_B   = 4;
   localparam int CTL_GANG        = 5;
   localparam int CTL_SHIFT_LSB   = 6;
   localparam int CTL_WIDTH       = 9;
   localparam logic [CTL_WIDTH-1:0] CTL_RESET = 9'h000;

   // ****************************************************************
   // Status and mask bits
   // ****************************************************************
   localparam int ST_INTERVAL = 0;
   localparam int ST_TICK     = 1;
   localparam int ST_WRAP     = 2;
   localparam int ST_CAP_A    = 3;
   localparam int ST_CAP_B    = 4;
   localparam int ST_WIDTH    = 5;

   localparam logic [15:0] INTERVAL_RESET = 16'h0000;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [7:0] rise;
      logic [7:0] fall;
   } capture_pair_type;

endpackage

// [edge_capture.sv]
// Edge capture channel: pin synchroniser, edge detect, rise and fall holding registers
`timescale 1ns/1ps
`default_nettype none

module edge_capture (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic                    pin,
   input  wire logic                    rise_en,
   input  wire logic                    fall_en,
   input  wire logic [7:0]              slice,
   output var  logic                    rise_seen,
   output var  logic                    fall_seen,
   output var  timer_pkg::capture_pair_type held,
   output var  logic                    event_pulse
);

   logic [2:0] sync;
   logic       level;

   // ****************************************************************
   // Three-stage synchroniser; a change counts once stages two and three agree
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync  <= 3'h0;
         level <= 1'b0;
      end else begin
         sync <= {sync[1:0], pin};
         if (sync[1] == sync[2]) begin
            level <= sync[2];
         end
      end
   end

   always_comb begin
      rise_seen = (sync[1] == sync[2]) && sync[2] && !level;
      fall_seen = (sync[1] == sync[2]) && !sync[2] && level;
   end

   // ****************************************************************
   // Separate registers keep both edge times
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         held        <= '0;
         event_pulse <= 1'b0;
      end else begin
         event_pulse <= (rise_seen && rise_en) || (fall_seen && fall_en);
         if (rise_seen && rise_en) begin
            held.rise <= slice;
         end
         if (fall_seen && fall_en) begin
            held.fall <= slice;
         end
      end
   end

endmodule

`default_nettype wire

// [timer_asserts.sv]
// Concurrent checks on the timer's register bus and interrupt output
`timescale 1ns/1ps
`default_nettype none

module timer_asserts (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        irq
);
   // ****************************************************************
   // Bus and interrupt properties
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer missing");
   a_read_refuse: assert property (
      s_axi_rvalid |-> !s_axi_arready) else $error("address taken during read answer");
   a_read_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped or changed");
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
      else $error("write response not two edges after take");
   a_write_refuse: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
   a_write_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped or changed");
   a_resp_release: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response repeated");
   // Status bits are sticky, so the line only drops through a register write
   a_irq_sticky: assert property (
      $fell(irq) |-> s_axi_bvalid) else $error("interrupt fell without a write");
   a_reset_quiet: assert property (
      $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
      else $error("outputs busy after reset");
endmodule

bind free_running_timer_capture timer_asserts chk (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq
);
`default_nettype wire

// [edge_source.sv]
// External edge sources driving the two capture pins
`timescale 1ns/1ps
`default_nettype none

module edge_source (
   output var logic pin_a,
   output var logic pin_b
);
   // ****************************************************************
   // Pin drive
   // ****************************************************************
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
   end

   // Pins are asynchronous to the block; lag sets how far off the clock edge they move
   task automatic set_pin(input logic chan, input logic lvl, input int lag_ns);
      #(lag_ns);
      if (chan) pin_b = lvl;
      else pin_a = lvl;
   endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking testbench of the free-running timer with capture channels
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module tb_top;
   // ****************************************************************
   // Signals and design
   // ****************************************************************
   logic        aclk;
   logic        aresetn;
   logic [7:0]  awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [7:0]  araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   logic        pin_a;
   logic        pin_b;
   logic        irq;
   int          n_fail;
   int          n_compared;
   logic [31:0] rv;
   logic [1:0]  rs;

   free_running_timer_capture dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .capture_input_a(pin_a), .capture_input_b(pin_b), .irq(irq));
   edge_source src (.pin_a(pin_a), .pin_b(pin_b));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // ****************************************************************
   // Bus tasks
   // ****************************************************************
   task automatic stop_test;
      $display("Mismatches %0d, comparisons %0d", n_fail, n_compared);
      if (n_fail == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic hang(input string what);
      n_fail++;
      $display("[FAIL] %s expected answer seen none", what);
      stop_test;
   endtask

   // Ready lags the answer by a cycle so the slave must hold its response
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      @(posedge aclk);
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            r = bresp; bready <= 1'b0; break;
         end
         if (bvalid) bready <= 1'b1;
      end
      if (k == 50) hang("write");
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            d = rdata; r = rresp; rready <= 1'b0; break;
         end
         if (rvalid) rready <= 1'b1;
      end
      if (k == 50) hang("read");
   endtask

   task automatic wait_irq(output int n);
      for (n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge aclk);
      if (n == 2000) hang("irq");
   endtask

   function automatic logic near(input logic [15:0] s, input logic [15:0] c, input int sh,
                                 input logic [15:0] m);
      return (((c >> sh) - s) & m) <= 16'h0001;
   endfunction

   // Edge on one pin, then the count, one capture register and the status
   task automatic edge_read(input logic ch, input logic lv, input int lag, input logic [7:0] a,
                            output logic [15:0] c, output logic [15:0] v,
                            output logic [4:0] st);
      src.set_pin(ch, lv, lag);
      repeat (10) @(posedge aclk);
      bus_rd(timer_pkg::ADDR_COUNT, rv, rs); c = rv[15:0];
      bus_rd(a, rv, rs); v = rv[15:0];
      bus_rd(timer_pkg::ADDR_STATUS, rv, rs); st = rv[4:0];
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset_bus;
      bus_rd(timer_pkg::ADDR_COUNT, rv, rs);
      `CHK("count", 16'h0000, rv[15:0])
      bus_rd(timer_pkg::ADDR_CONTROL, rv, rs);
      `CHK("control", timer_pkg::CTL_RESET, rv[8:0])
      bus_rd(timer_pkg::ADDR_STATUS, rv, rs);
      `CHK("status", 5'h00, rv[4:0])
      bus_rd(timer_pkg::ADDR_MASK, rv, rs);
      `CHK("mask", 5'h00, rv[4:0])
      bus_rd(timer_pkg::ADDR_INTERVAL, rv, rs);
      `CHK("interval", timer_pkg::INTERVAL_RESET, rv[15:0])
      bus_rd(8'h24, rv, rs);
      `CHK("unmapped read", timer_pkg::RESP_SLVERR, rs)
      bus_wr(timer_pkg::ADDR_COUNT, 32'h0000_1234, rs);
      `CHK("read-only write", timer_pkg::RESP_SLVERR, rs)
   endtask

   task automatic t_count_rate;
      logic [15:0] c0;
      bus_rd(timer_pkg::ADDR_COUNT, rv, rs); c0 = rv[15:0];
      repeat (1000) @(posedge aclk);
      bus_rd(timer_pkg::ADDR_COUNT, rv, rs);
      `CHK("count step", 1'b1, near(c0 + 16'd10, rv[15:0], 0, 16'hFFFF))
   endtask

   task automatic t_interval;
      int n;
      bus_wr(timer_pkg::ADDR_INTERVAL, 32'h0000_0004, rs);
      `CHK("interval write", timer_pkg::RESP_OKAY, rs)
      bus_wr(timer_pkg::ADDR_MASK, 32'h0000_0001, rs);
      bus_wr(timer_pkg::ADDR_CONTROL, 32'h0000_0001, rs);
      wait_irq(n);
      bus_wr(timer_pkg::ADDR_STATUS, 32'h0000_0001, rs);
      `CHK("irq cleared", 1'b0, irq)
      wait_irq(n);
      `CHK("5 us period", 1'b1, n >= 480 && n <= 500)
      bus_wr(timer_pkg::ADDR_CONTROL, 32'h0000_0000, rs);
      bus_wr(timer_pkg::ADDR_STATUS, 32'h0000_001F, rs);
   endtask

   task automatic t_capture;
      logic [15:0] c;
      logic [15:0] v;
      logic [15:0] r0;
      logic [4:0]  st;
      bus_wr(timer_pkg::ADDR_MASK, 32'h0000_0008, rs);
      bus_wr(timer_pkg::ADDR_CONTROL, 32'h0000_0006, rs);
      edge_read(1'b0, 1'b1, 3, timer_pkg::ADDR_A_RISE, c, r0, st);
      `CHK("a rise slice", 1'b1, near(r0[7:0], c, 0, 16'h00FF))
      `CHK("a status", 1'b1, st[3])
      `CHK("irq a", 1'b1, irq)
      bus_wr(timer_pkg::ADDR_STATUS, 32'h0000_0008, rs);
      edge_read(1'b0, 1'b0, 47, timer_pkg::ADDR_A_FALL, c, v, st);
      `CHK("a fall slice", 1'b1, near(v[7:0], c, 0, 16'h00FF))
      bus_rd(timer_pkg::ADDR_A_RISE, rv, rs);
      `CHK("a rise kept", r0[7:0], rv[7:0])
      bus_wr(timer_pkg::ADDR_STATUS, 32'h0000_001F, rs);
      bus_wr(timer_pkg::ADDR_CONTROL, 32'h0000_0108, rs);
      edge_read(1'b1, 1'b1, 3, timer_pkg::ADDR_B_RISE, c, v, st);
      `CHK("b rise slice", 1'b1, near(v[7:0], c, 4, 16'h00FF))
      `CHK("b status", 2'b10, st[4:3])
      bus_wr(timer_pkg::ADDR_STATUS, 32'h0000_001F, rs);
      edge_read(1'b1, 1'b0, 3, timer_pkg::ADDR_B_FALL, c, v, st);
      `CHK("b fall off", 1'b0, st[4])
   endtask

   task automatic t_gang;
      logic [15:0] c;
      logic [15:0] v;
      logic [4:0]  st;
      bus_wr(timer_pkg::ADDR_STATUS, 32'h0000_001F, rs);
      bus_wr(timer_pkg::ADDR_CONTROL, 32'h0000_002A, rs);
      edge_read(1'b0, 1'b1, 3, timer_pkg::ADDR_A_RISE, c, v, st);
      `CHK("gang value", 1'b1, near(v, c, 0, 16'hFFFF))
      `CHK("gang status", 1'b1, st[3])
      edge_read(1'b1, 1'b1, 47, timer_pkg::ADDR_B_RISE, c, v, st);
      `CHK("gang b quiet", 1'b0, st[4])
   endtask

   initial begin
      aresetn = 1'b0; awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wvalid = 1'b0;
      bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
      n_fail = 0; n_compared = 0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset_bus;
      t_count_rate;
      t_interval;
      t_capture;
      t_gang;
      stop_test;
   end
endmodule
`default_nettype wire
